// file: rtl/fmc_id_check.sv
// Registered comparison of programmer keys against stored lock words.
// Assumes the stored words are stable copies read from the vector area.
`timescale 1ns/1ps
module fmc_id_check (
    input  wire logic                    clock_in,
    input  wire logic                    reset_in,
    input  wire logic [fmc_pkg::ID_W-1:0] stored_id_in,
    input  wire logic [fmc_pkg::ID_W-1:0] key_in,
    input  wire logic [7:0]              option_word_in,
    output logic                         serial_ok_out,
    output logic                         parallel_ok_out
);

    // ------------------------------------------------------------
    // Lock decisions
    // ------------------------------------------------------------
    // Locked out of reset until the first compare has run
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            serial_ok_out   <= 1'b0;
            parallel_ok_out <= 1'b0;
        end else begin
            serial_ok_out   <= (stored_id_in == key_in);
            parallel_ok_out <= (option_word_in == fmc_pkg::OFS_UNLOCK);
        end
    end

endmodule : fmc_id_check

// file: rtl/fmc_pkg.sv
// Constants, types and register map of the flash rewrite mode control.
// Assumes one 100 MHz clock and an asynchronous active-high reset.
//
// Overview of operation
// - Wrong ID code blocks flash access in serial programming mode.
// - Wrong option-select word blocks parallel programming flash access.
// - Rewrite enable forces area expansion to one; clearing restores it.
// - Area-expansion writes during rewrite stay pending until rewrite ends.
// - Rewrite mode holds area select and area expansion at one.
// - Reset or listed interrupts suspend program, erase, lock-bit program.
package fmc_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_FLASH_CTRL = 8'h00;
    localparam logic [7:0] OFS_PROC_MODE  = 8'h04;
    localparam logic [7:0] OFS_FLASH_CMD  = 8'h08;
    localparam logic [7:0] OFS_ID_KEY_LO  = 8'h0C;
    localparam logic [7:0] OFS_ID_KEY_HI  = 8'h10;
    localparam logic [7:0] OFS_ACCESS     = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_REWRITE_EN  = 0;
    localparam int CTRL_FLASH_EXEC  = 1;
    localparam int CTRL_DF_WAIT     = 2;
    localparam int CTRL_READY       = 3;
    localparam int CTRL_SUSPENDED   = 4;
    localparam int CTRL_IGNORED     = 5;
    localparam int PM_AREA_SELECT   = 0;
    localparam int PM_AREA_EXPAND   = 3;
    localparam int PM_WAIT_STATE    = 7;
    localparam int ACC_SERIAL_OK    = 0;
    localparam int ACC_PARALLEL_OK  = 1;

    // ------------------------------------------------------------
    // Reset values and keys
    // ------------------------------------------------------------
    localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
    localparam logic [7:0]  OFS_UNLOCK    = 8'hFF;
    localparam int          ID_BYTES      = 7;
    localparam int          ID_W          = 8 * ID_BYTES;

    // ------------------------------------------------------------
    // Timing: time of one automatic operation
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int OP_TIME_NS     = 640;
    localparam int OP_CYCLES      = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W          = 16;

    // ------------------------------------------------------------
    // Commands and states
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        FMC_CMD_PROGRAM    = 8'h01,
        FMC_CMD_ERASE      = 8'h02,
        FMC_CMD_LOCK_PROG  = 8'h03,
        FMC_CMD_LOCK_READ  = 8'h04,
        FMC_CMD_BLANK      = 8'h05
    } fmc_cmd_t;

    typedef enum logic [0:0] {
        FMC_IDLE = 1'b0,
        FMC_BUSY = 1'b1
    } fmc_state_t;

    // Events that break off an automatic operation
    typedef struct packed {
        logic nmi;
        logic watchdog;
        logic osc_stop;
        logic volt_mon1;
        logic volt_mon2;
    } fmc_susp_t;

endpackage : fmc_pkg

// file: rtl/fmc_rewrite_ctrl.sv
// Flash rewrite mode control: rewrite enable, forced memory-map bits,
// command acceptance, suspension and programming-mode lockout.
// Assumes a plain register port and software that obeys the usage notes.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module fmc_rewrite_ctrl #(
    parameter int OP_CYCLES = fmc_pkg::OP_CYCLES
) (
    input  wire logic                     clock_in,
    input  wire logic                     reset_in,
    input  wire logic [7:0]               addr_in,
    input  wire logic [31:0]              wr_data_in,
    input  wire logic                     wr_in,
    input  wire logic                     rd_in,
    output logic      [31:0]              rd_data_out,
    input  wire fmc_pkg::fmc_susp_t       susp_in,
    input  wire logic [fmc_pkg::ID_W-1:0] stored_id_in,
    input  wire logic [7:0]               option_word_in,
    input  wire logic                     serial_mode_in,
    input  wire logic                     parallel_mode_in,
    output logic                          flash_ready_flag_out,
    output logic                          op_start_out,
    output logic      [7:0]               op_cmd_out,
    output logic                          op_abort_out,
    output logic                          flash_area_select_out,
    output logic                          internal_area_expand_out,
    output logic                          wait_state_out,
    output logic                          serial_access_out,
    output logic                          parallel_access_out
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic                     cpu_rewrite_enable;
    logic                     flash_executed_rewrite_mode;
    logic                     data_flash_wait_bit;
    logic                     general_wait_state_bit;
    logic                     area_select_user;
    logic                     expand_user;
    logic                     expand_pend;
    logic                     pend_valid;
    logic                     suspended;
    logic                     cmd_ignored;
    logic [fmc_pkg::ID_W-1:0] id_key;
    logic [fmc_pkg::CNT_W-1:0] busy_cnt;
    logic [7:0]               cur_cmd;
    logic                     serial_ok;
    logic                     parallel_ok;
    fmc_pkg::fmc_state_t      state;

    logic wr_ctrl;
    logic wr_pm;
    logic wr_cmd;
    logic susp_hit;
    logic cmd_known;
    logic suspendable;

    // Register selects
    assign wr_ctrl   = wr_in && (addr_in == fmc_pkg::OFS_FLASH_CTRL);
    assign wr_pm     = wr_in && (addr_in == fmc_pkg::OFS_PROC_MODE);
    assign wr_cmd    = wr_in && (addr_in == fmc_pkg::OFS_FLASH_CMD);
    assign susp_hit  = |susp_in;
    assign cmd_known = (wr_data_in[7:0] >= fmc_pkg::FMC_CMD_PROGRAM)
                    && (wr_data_in[7:0] <= fmc_pkg::FMC_CMD_BLANK);
    // Read lock status and blank check run on through an interrupt
    assign suspendable = (cur_cmd == fmc_pkg::FMC_CMD_PROGRAM)
                      || (cur_cmd == fmc_pkg::FMC_CMD_ERASE)
                      || (cur_cmd == fmc_pkg::FMC_CMD_LOCK_PROG);

    // ------------------------------------------------------------
    // Rewrite control bits
    // ------------------------------------------------------------
    // Mode select is frozen while rewrite is enabled to keep it coherent
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            cpu_rewrite_enable  <= 1'b0;
            flash_executed_rewrite_mode <= 1'b0;
            data_flash_wait_bit <= 1'b0;
        end else if (wr_ctrl) begin
            cpu_rewrite_enable  <= wr_data_in[fmc_pkg::CTRL_REWRITE_EN];
            data_flash_wait_bit <= wr_data_in[fmc_pkg::CTRL_DF_WAIT];
            if (!cpu_rewrite_enable) begin
                flash_executed_rewrite_mode <=
                    wr_data_in[fmc_pkg::CTRL_FLASH_EXEC];
            end
        end
    end

    // ------------------------------------------------------------
    // Processor mode bits with pending expansion write
    // ------------------------------------------------------------
    // Expansion value survives rewrite mode; expansion writes then only land in pending
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            general_wait_state_bit <= 1'b0;
            area_select_user       <= 1'b0;
            expand_user            <= 1'b0;
            expand_pend            <= 1'b0;
            pend_valid             <= 1'b0;
        end else begin
            if (wr_pm) begin
                general_wait_state_bit <= wr_data_in[fmc_pkg::PM_WAIT_STATE];
                area_select_user <= wr_data_in[fmc_pkg::PM_AREA_SELECT];
            end
            if (wr_pm && cpu_rewrite_enable) begin
                expand_pend <= wr_data_in[fmc_pkg::PM_AREA_EXPAND];
                pend_valid  <= 1'b1;
            end else if (wr_pm) begin
                expand_user <= wr_data_in[fmc_pkg::PM_AREA_EXPAND];
            end else if (!cpu_rewrite_enable && pend_valid) begin
                expand_user <= expand_pend;
                pend_valid  <= 1'b0;
            end
        end
    end

    // Forced memory-map outputs and wait state, one cycle behind the bits
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            flash_area_select_out    <= 1'b0;
            internal_area_expand_out <= 1'b0;
            wait_state_out           <= 1'b0;
        end else begin
            flash_area_select_out <= cpu_rewrite_enable | area_select_user;
            internal_area_expand_out <= cpu_rewrite_enable | expand_user;
            wait_state_out <= general_wait_state_bit | data_flash_wait_bit;
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    // A new command during a busy operation is ignored, not queued
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state                <= fmc_pkg::FMC_IDLE;
            busy_cnt             <= '0;
            cur_cmd              <= 8'h00;
            flash_ready_flag_out <= 1'b1;
            op_start_out         <= 1'b0;
            op_abort_out         <= 1'b0;
        end else begin
            op_start_out <= 1'b0;
            op_abort_out <= 1'b0;
            case (state)
                fmc_pkg::FMC_IDLE: begin
                    if (wr_cmd && cmd_known && cpu_rewrite_enable) begin
                        state                <= fmc_pkg::FMC_BUSY;
                        cur_cmd              <= wr_data_in[7:0];
                        busy_cnt <= fmc_pkg::CNT_W'(OP_CYCLES - 1);
                        flash_ready_flag_out <= 1'b0;
                        op_start_out         <= 1'b1;
                    end
                end
                fmc_pkg::FMC_BUSY: begin
                    if (susp_hit && suspendable) begin
                        state                <= fmc_pkg::FMC_IDLE;
                        flash_ready_flag_out <= 1'b1;
                        op_abort_out         <= 1'b1;
                    end else if (busy_cnt == '0) begin
                        state                <= fmc_pkg::FMC_IDLE;
                        flash_ready_flag_out <= 1'b1;
                    end else begin
                        busy_cnt <= busy_cnt - 1'b1;
                    end
                end
                default: begin
                    state                <= fmc_pkg::FMC_IDLE;
                    flash_ready_flag_out <= 1'b1;
                end
            endcase
        end
    end

    assign op_cmd_out = cur_cmd;

    // Sticky flags: set wins over a write-one clear
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            suspended   <= 1'b0;
            cmd_ignored <= 1'b0;
        end else begin
            if (state == fmc_pkg::FMC_BUSY && susp_hit && suspendable) begin
                suspended <= 1'b1;
            end else if (wr_ctrl && wr_data_in[fmc_pkg::CTRL_SUSPENDED]) begin
                suspended <= 1'b0;
            end
            if (wr_cmd && (!cpu_rewrite_enable || !cmd_known)) begin
                cmd_ignored <= 1'b1;
            end else if (wr_ctrl && wr_data_in[fmc_pkg::CTRL_IGNORED]) begin
                cmd_ignored <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Programming-mode lockout
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            id_key <= '0;
        end else if (wr_in && addr_in == fmc_pkg::OFS_ID_KEY_LO) begin
            id_key[31:0] <= wr_data_in;
        end else if (wr_in && addr_in == fmc_pkg::OFS_ID_KEY_HI) begin
            id_key[fmc_pkg::ID_W-1:32] <= wr_data_in[fmc_pkg::ID_W-33:0];
        end
    end

    fmc_id_check fmc_id_check_i (
        .clock_in        (clock_in),
        .reset_in        (reset_in),
        .stored_id_in    (stored_id_in),
        .key_in          (id_key),
        .option_word_in  (option_word_in),
        .serial_ok_out   (serial_ok),
        .parallel_ok_out (parallel_ok)
    );

    // Access grant only in the matching programming mode
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            serial_access_out   <= 1'b0;
            parallel_access_out <= 1'b0;
        end else begin
            serial_access_out   <= serial_mode_in && serial_ok;
            parallel_access_out <= parallel_mode_in && parallel_ok;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Data stand only in the cycle after the strobe; unmapped read zero
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rd_data_out <= fmc_pkg::RESET_WORD;
        end else begin
            rd_data_out <= fmc_pkg::RESET_WORD;
            if (rd_in) begin
                case (addr_in)
                    fmc_pkg::OFS_FLASH_CTRL: begin
                        rd_data_out <= {26'h000_0000, cmd_ignored, suspended,
                            flash_ready_flag_out, data_flash_wait_bit,
                            flash_executed_rewrite_mode, cpu_rewrite_enable};
                    end
                    fmc_pkg::OFS_PROC_MODE: begin
                        rd_data_out <= {24'h00_0000, general_wait_state_bit,
                            3'h0, internal_area_expand_out, 2'h0,
                            flash_area_select_out};
                    end
                    fmc_pkg::OFS_FLASH_CMD: begin
                        rd_data_out <= {24'h00_0000, cur_cmd};
                    end
                    fmc_pkg::OFS_ACCESS: begin
                        rd_data_out <= {30'h0000_0000, parallel_ok, serial_ok};
                    end
                    default: begin
                        rd_data_out <= fmc_pkg::RESET_WORD;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_expand_forced;
        @(posedge clock_in) disable iff (reset_in)
        cpu_rewrite_enable |=> internal_area_expand_out;
    endproperty
    a_expand_forced: assert property (p_expand_forced)
        else $error("area expansion not forced in rewrite");

    property p_pending_held;
        @(posedge clock_in) disable iff (reset_in)
        (wr_pm && cpu_rewrite_enable) |=> $stable(expand_user);
    endproperty
    a_pending_held: assert property (p_pending_held)
        else $error("expansion write applied during rewrite");

    property p_select_forced;
        @(posedge clock_in) disable iff (reset_in)
        cpu_rewrite_enable [*2] |-> flash_area_select_out
            && internal_area_expand_out;
    endproperty
    a_select_forced: assert property (p_select_forced)
        else $error("map bits not held at one in rewrite");

    property p_suspend;
        @(posedge clock_in) disable iff (reset_in)
        (state == fmc_pkg::FMC_BUSY && susp_hit && suspendable)
            |=> flash_ready_flag_out && op_abort_out && suspended;
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("operation not suspended");

    property p_cmd_gate;
        @(posedge clock_in) disable iff (reset_in)
        (wr_cmd && !cpu_rewrite_enable) |=> !op_start_out && cmd_ignored;
    endproperty
    a_cmd_gate: assert property (p_cmd_gate)
        else $error("command accepted with rewrite disabled");

    property p_serial_lock;
        @(posedge clock_in) disable iff (reset_in)
        serial_access_out |-> $past(serial_mode_in) && $past(serial_ok);
    endproperty
    a_serial_lock: assert property (p_serial_lock)
        else $error("serial access granted without key match");

    property p_parallel_lock;
        @(posedge clock_in) disable iff (reset_in)
        parallel_access_out |-> $past(parallel_ok, 1)
            && $past(option_word_in, 2) == fmc_pkg::OFS_UNLOCK;
    endproperty
    a_parallel_lock: assert property (p_parallel_lock)
        else $error("parallel access granted with wrong option word");

endmodule : fmc_rewrite_ctrl

// file: tb/tb_flash_rewrite_mode_control.sv
// Self-checking bench for the flash rewrite mode control block.
// Assumes fmc_pkg is compiled first; assertions live in the design files.
`timescale 1ns/1ps
module tb_flash_rewrite_mode_control;
    // ------------------------------------------------------------
    // Stimulus, observation and bookkeeping
    // ------------------------------------------------------------
    localparam int OPC = 4;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] EN  = ONE << fmc_pkg::CTRL_REWRITE_EN;
    localparam logic [31:0] RDY = ONE << fmc_pkg::CTRL_READY;
    localparam logic [31:0] SUS = ONE << fmc_pkg::CTRL_SUSPENDED;
    localparam logic [31:0] IGN = ONE << fmc_pkg::CTRL_IGNORED;
    localparam logic [55:0] ID  = 56'h0012_3456_789A_BCDE;
    logic                clock_in = 1'b0, reset_in = 1'b1;
    logic [7:0]          addr = 8'h00, opt = 8'h00;
    logic [31:0]         wdata = 32'h0000_0000, rdata, q;
    logic                wr_s = 1'b0, rd_s = 1'b0, smode = 1'b0, pmode = 1'b0;
    fmc_pkg::fmc_susp_t  susp = '0;
    logic                ready, start, abort, asel, aexp, wst, sacc, pacc;
    logic [7:0]          cmd;
    int                  errors = 0, compares = 0, starts = 0, aborts = 0;

    fmc_rewrite_ctrl #(.OP_CYCLES(OPC)) fmc_rewrite_ctrl_i (
        .clock_in(clock_in), .reset_in(reset_in), .addr_in(addr),
        .wr_data_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rd_data_out(rdata),
        .susp_in(susp), .stored_id_in(ID), .option_word_in(opt),
        .serial_mode_in(smode), .parallel_mode_in(pmode),
        .flash_ready_flag_out(ready), .op_start_out(start),
        .op_cmd_out(cmd), .op_abort_out(abort),
        .flash_area_select_out(asel), .internal_area_expand_out(aexp),
        .wait_state_out(wst), .serial_access_out(sacc),
        .parallel_access_out(pacc));

    // Clock; pulse counters catch one-cycle outputs without racing
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        if (start === 1'b1) starts++;
        if (abort === 1'b1) aborts++;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr <= a; wdata <= d; wr_s <= 1'b1;
        @(posedge clock_in);
        wr_s <= 1'b0;
        #1;
    endtask : wr
    // Data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a);
        @(posedge clock_in);
        addr <= a; rd_s <= 1'b1;
        @(posedge clock_in);
        rd_s <= 1'b0;
        #1 q = rdata;
    endtask : rd
    task automatic settle();
        repeat (3) @(posedge clock_in);
        #1;
    endtask : settle
    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_cmds();
        int s0;
        s0 = starts;
        wr(fmc_pkg::OFS_FLASH_CMD, 32'h0000_0001);
        settle();
        chk("start_off", starts, s0);
        rd(fmc_pkg::OFS_FLASH_CTRL);
        chk("ctrl_ign", q, RDY | IGN);
        wr(fmc_pkg::OFS_PROC_MODE, ONE << fmc_pkg::PM_WAIT_STATE);
        wr(fmc_pkg::OFS_FLASH_CTRL, EN | IGN);
        for (int c = 1; c <= 6; c++) begin
            s0 = starts;
            wr(fmc_pkg::OFS_FLASH_CMD, 32'(c));
            chk("busy", ready, (c == 6) ? 1'b1 : 1'b0);
            if (c < 6) begin
                wr(fmc_pkg::OFS_FLASH_CMD, 32'h0000_0002);
                repeat (OPC - 3) @(posedge clock_in);
                #1 chk("busy_end", ready, 1'b0);
                @(posedge clock_in);
                #1 chk("ready_back", ready, 1'b1);
                chk("one_start", starts, s0 + 1);
                chk("cmd_code", cmd, c[7:0]);
            end
        end
        rd(fmc_pkg::OFS_FLASH_CTRL);
        chk("bad_code", q & IGN, IGN);
        $display("test commands done");
    endtask : t_cmds

    task automatic t_area();
        wr(fmc_pkg::OFS_FLASH_CTRL, IGN);
        wr(fmc_pkg::OFS_PROC_MODE, ONE << fmc_pkg::PM_AREA_EXPAND);
        settle();
        chk("aexp_set", aexp, 1'b1);
        chk("no_wait", wst, 1'b0);
        wr(fmc_pkg::OFS_FLASH_CTRL, EN);
        wr(fmc_pkg::OFS_PROC_MODE, 32'h0000_0000);
        settle();
        chk("aexp_forced", aexp, 1'b1);
        chk("asel_forced", asel, 1'b1);
        wr(fmc_pkg::OFS_FLASH_CTRL, 32'h0000_0000);
        settle();
        chk("aexp_pending", aexp, 1'b0);
        chk("asel_back", asel, 1'b0);
        wr(fmc_pkg::OFS_PROC_MODE, ONE << fmc_pkg::PM_WAIT_STATE);
        settle();
        chk("gen_wait", wst, 1'b1);
        wr(fmc_pkg::OFS_PROC_MODE, 32'h0000_0000);
        wr(fmc_pkg::OFS_FLASH_CTRL, ONE << fmc_pkg::CTRL_DF_WAIT);
        settle();
        chk("df_wait", wst, 1'b1);
        $display("test area bits done");
    endtask : t_area

    task automatic t_susp();
        int a0;
        wr(fmc_pkg::OFS_PROC_MODE, ONE << fmc_pkg::PM_WAIT_STATE);
        wr(fmc_pkg::OFS_FLASH_CTRL, EN);
        for (int b = 0; b < 6; b++) begin
            a0 = aborts;
            wr(fmc_pkg::OFS_FLASH_CMD, (b == 5) ? 32'h0000_0004
                                                : 32'((b + 2) % 3 + 1));
            // Non-maskable event meets a program, never an erase
            susp <= (b == 5) ? 5'b1_0000 : (5'b0_0001 << b);
            @(posedge clock_in);
            susp <= '0;
            #1 chk("susp_ready", ready, (b == 5) ? 1'b0 : 1'b1);
            settle();
            chk("abort", aborts, a0 + ((b == 5) ? 0 : 1));
            repeat (OPC) @(posedge clock_in);
        end
        rd(fmc_pkg::OFS_FLASH_CTRL);
        chk("susp_flag", q & SUS, SUS);
        wr(fmc_pkg::OFS_FLASH_CTRL, SUS);
        rd(fmc_pkg::OFS_FLASH_CTRL);
        chk("susp_clear", q, RDY);
        $display("test suspend done");
    endtask : t_susp

    task automatic t_lock();
        smode <= 1'b1;
        pmode <= 1'b1;
        opt <= 8'h5A;
        wr(fmc_pkg::OFS_ID_KEY_LO, ID[31:0]);
        wr(fmc_pkg::OFS_ID_KEY_HI, {8'h00, ID[55:32]});
        settle();
        chk("serial_ok", sacc, 1'b1);
        chk("parallel_bad", pacc, 1'b0);
        opt <= 8'hFF;
        wr(fmc_pkg::OFS_ID_KEY_LO, ~ID[31:0]);
        settle();
        chk("serial_bad", sacc, 1'b0);
        chk("parallel_ok", pacc, 1'b1);
        rd(8'h40);
        chk("unmapped", q, 32'h0000_0000);
        rd(fmc_pkg::OFS_ACCESS);
        chk("access_bits", q, 32'h0000_0002);
        pmode <= 1'b0;
        settle();
        chk("parallel_mode", pacc, 1'b0);
        $display("test lockout done");
    endtask : t_lock

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        settle();
        chk("ready_rst", ready, 1'b1);
        chk("aexp_rst", aexp, 1'b0);
        t_cmds();
        t_area();
        t_susp();
        t_lock();
        test_done();
    end
    initial begin
        #50000;
        errors++;
        test_done();
    end
endmodule : tb_flash_rewrite_mode_control
